// ==== verilog/bbpc_top.sv ====
// boot command interpreter: boundary query and parameter store, byte fifo
// assumes byte streams and control inputs come from logic on clk
// Behaviour
// - query packet is 01,00,01,4F,B0,03
// - query success replies boundary data packet
// - sizes sent in kilobytes, high byte first
// - failure replies status packet with code
// - bytes before start byte are discarded
// - missing end byte gives packet error
// - bad checksum gives checksum error
// - wrong length gives packet error
// - errors change nothing, back to waiting
// - query after encrypted write is refused
// - good query sends sizes, memory untouched
// - only highest priority error is reported
// - error detail and address hold unused code
// - store packet carries identifier and value
// - identifiers allowed per authentication level
// - value with low three bits zero selects the disable action
// - level-two key off blocks init and return
// - bad identifier or value, or level refusal
`timescale 1ns/10ps
`default_nettype none

module bbpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  output logic [WIDTH-1:0] out_data, // head data
  output logic out_valid, // head present
  input wire logic out_ready // head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes and flags
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count < (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module bbpc_top (
  input wire logic clk, // 20 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] rx_data, // received command byte
  input wire logic rx_valid, // byte present
  output logic rx_ready, // byte accepted this cycle
  output logic [7:0] tx_data, // reply byte
  output logic tx_valid, // reply byte present
  input wire logic tx_ready, // reply byte taken
  input wire logic [1:0] auth_level, // current authentication level
  input wire logic enc_write_done, // pulse: encrypted write executed
  input wire logic [15:0] code_secure_size, // stored code boundary, KB
  input wire logic [15:0] data_secure_size, // stored data boundary, KB
  output logic disable_init, // initialization disabled
  output logic disable_locked_boot, // locked boot transition disabled
  output logic disable_level_two_key, // level-two key auth disabled
  output logic disable_level_one_key, // level-one key auth disabled
  output logic init_refused, // initialization blocked
  output logic rma_refused // return request blocked
);
  import bbpc_pkg::*;

  bbpc_state_t state;
  bbpc_reply_t rsp;
  bbpc_reply_t next_rsp;
  logic [15:0] len;
  logic [15:0] cnt;
  logic [7:0] acc;
  logic [7:0] pl [3];
  logic enc_seen;
  logic take;
  logic decide;
  logic drop;
  logic param_ok;
  logic [3:0] idx;
  logic [7:0] tx_acc;
  logic [7:0] push_data;
  logic push;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  // one byte of the outgoing packet; sum position emits the negated running sum
  function automatic logic [7:0] reply_byte(bbpc_reply_t r, logic [3:0] i, logic [7:0] s);
    logic [3:0] last;
    logic [7:0] b;
    last = r.data_kind ? LAST_DATA : LAST_STATUS;
    b = ZERO_BYTE;
    if (i == 4'h0) begin
      b = REPLY_START_BYTE;
    end else if (i == IDX_LEN_HIGH) begin
      b = LEN_HIGH_ZERO;
    end else if (i == IDX_LEN_LOW) begin
      b = r.data_kind ? LEN_QUERY_REPLY : LEN_STATUS_REPLY;
    end else if (i == IDX_RESP) begin
      b = r.resp;
    end else if (i == last) begin
      b = END_BYTE;
    end else if (i == last - 4'h1) begin
      b = 8'(~s + 8'h01);
    end else if (r.data_kind) begin
      case (i)
        IDX_CODE_HI: b = r.csize[15:8];
        IDX_CODE_LO: b = r.csize[7:0];
        IDX_DATA_HI: b = r.dsize[15:8];
        IDX_DATA_LO: b = r.dsize[7:0];
        default: b = ZERO_BYTE;
      endcase
    end else if (i == IDX_STAT) begin
      b = r.stat;
    end else begin
      b = UNUSED_CODE[7:0];
    end
    return b;
  endfunction

  assign take = rx_valid && rx_ready;
  assign decide = take && (state == ST_END);

  // verdict at the end byte, checks in falling priority
  always_comb begin
    logic is_query;
    logic is_param;
    logic [15:0] want;
    logic lvl_ok;
    logic lvl_one_up;
    is_query = (pl[0] == CMD_QUERY);
    is_param = (pl[0] == CMD_PARAM);
    want = is_query ? LEN_QUERY_CMD : LEN_PARAM_CMD;
    lvl_ok = 1'b0;
    lvl_one_up = (auth_level == AUTH_LEVEL_ONE) || (auth_level == AUTH_LEVEL_TWO);
    drop = !(is_query || is_param);
    param_ok = 1'b0;
    next_rsp.data_kind = 1'b0;
    next_rsp.resp = is_query ? RSP_QUERY_ERR : RSP_PARAM_ERR;
    next_rsp.csize = code_secure_size;
    next_rsp.dsize = data_secure_size;
    next_rsp.stat = STAT_OK;
    // level code 3 is no level: only the always-allowed identifier passes
    case (pl[1])
      PID_INIT: lvl_ok = 1'b1;
      PID_LOCKED_BOOT: lvl_ok = lvl_one_up;
      PID_L1_KEY: lvl_ok = lvl_one_up;
      PID_L2_KEY: lvl_ok = (auth_level == AUTH_LEVEL_TWO);
      default: lvl_ok = 1'b0;
    endcase
    if (rx_data != END_BYTE) begin
      next_rsp.stat = STAT_PACKET_ERR;
    end else if (acc != ZERO_BYTE) begin
      next_rsp.stat = STAT_CHECKSUM_ERR;
    end else if (len == 16'h0000 || len > FMT_MAX_LEN) begin
      next_rsp.stat = STAT_PACKET_ERR;
    end else if (len != want) begin
      next_rsp.stat = STAT_PACKET_ERR;
    end else if (is_query) begin
      if (enc_seen) begin
        next_rsp.stat = STAT_ACCEPT_ERR;
      end else begin
        next_rsp.data_kind = 1'b1;
        next_rsp.resp = CMD_QUERY;
      end
    end else if (pl[1] < PID_INIT || pl[1] > PID_L1_KEY) begin
      next_rsp.stat = STAT_PARAM_ERR;
    end else if (!lvl_ok) begin
      next_rsp.stat = STAT_SECURE_ERR;
    end else if (enc_seen && pl[1] == PID_L1_KEY) begin
      next_rsp.stat = STAT_ACCEPT_ERR;
    end else if (pl[2][2:0] != VAL_DISABLE) begin
      next_rsp.stat = STAT_PARAM_ERR;
    end else begin
      next_rsp.resp = CMD_PARAM;
      param_ok = 1'b1;
    end
  end

  // packet walk: start hunt, length, body, sum, end, reply
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      rx_ready <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && rx_data == CMD_START_BYTE) begin
            state <= ST_LEN_HIGH;
          end
        end
        ST_LEN_HIGH: begin
          if (take) begin
            state <= ST_LEN_LOW;
          end
        end
        ST_LEN_LOW: begin
          if (take) begin
            state <= ({len[15:8], rx_data} == 16'h0000) ? ST_SUM : ST_BODY;
          end
        end
        ST_BODY: begin
          if (take && cnt == len - 16'h0001) begin
            state <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (take) begin
            state <= ST_END;
          end
        end
        ST_END: begin
          if (take) begin
            state <= drop ? ST_IDLE : ST_REPLY;
            rx_ready <= drop;
          end
        end
        ST_REPLY: begin
          if (push && idx == (rsp.data_kind ? LAST_DATA : LAST_STATUS)) begin
            state <= ST_IDLE;
            rx_ready <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          rx_ready <= 1'b1;
        end
      endcase
    end
  end

  // length, body count, payload capture and receive checksum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len <= '0;
      cnt <= '0;
      acc <= '0;
      pl[0] <= '0;
      pl[1] <= '0;
      pl[2] <= '0;
    end else if (take) begin
      if (state == ST_IDLE) begin
        acc <= '0;
        cnt <= '0;
        pl[0] <= '0;
        pl[1] <= '0;
        pl[2] <= '0;
      end else if (state == ST_LEN_HIGH) begin
        len[15:8] <= rx_data;
        acc <= acc + rx_data;
      end else if (state == ST_LEN_LOW) begin
        len[7:0] <= rx_data;
        acc <= acc + rx_data;
      end else if (state == ST_BODY || state == ST_SUM) begin
        acc <= acc + rx_data;
        cnt <= cnt + 16'h0001;
        if (state == ST_BODY && cnt < 16'h0003) begin
          pl[cnt[1:0]] <= rx_data;
        end
      end
    end
  end

  // encrypted write seen since reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_seen <= 1'b0;
    end else if (enc_write_done) begin
      enc_seen <= 1'b1;
    end
  end

  // reply descriptor captured at the verdict
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else if (decide && !drop) begin
      rsp <= next_rsp;
    end
  end

  // disable flags, set only on an accepted store; cleared only by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disable_init <= 1'b0;
      disable_locked_boot <= 1'b0;
      disable_level_two_key <= 1'b0;
      disable_level_one_key <= 1'b0;
    end else if (decide && param_ok) begin
      disable_init <= disable_init | (pl[1] == PID_INIT);
      disable_locked_boot <= disable_locked_boot | (pl[1] == PID_LOCKED_BOOT);
      disable_level_two_key <= disable_level_two_key | (pl[1] == PID_L2_KEY);
      disable_level_one_key <= disable_level_one_key | (pl[1] == PID_L1_KEY);
    end
  end

  // derived refusals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_refused <= 1'b0;
      rma_refused <= 1'b0;
    end else begin
      init_refused <= disable_init | disable_level_two_key;
      rma_refused <= disable_level_two_key;
    end
  end

  // reply byte generator, stalled by the fifo
  assign push = (state == ST_REPLY) && fifo_ready;
  assign push_data = reply_byte(rsp, idx, tx_acc);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= '0;
      tx_acc <= '0;
    end else if (state != ST_REPLY) begin
      idx <= '0;
      tx_acc <= '0;
    end else if (push) begin
      idx <= idx + 4'h1;
      if (idx != 4'h0) begin
        tx_acc <= tx_acc + push_data;
      end
    end
  end

  bbpc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(push_data),
    .in_valid(state == ST_REPLY),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // registered output stage
  assign fifo_pop = !tx_valid || tx_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (fifo_pop) begin
      tx_valid <= fifo_valid;
      tx_data <= fifo_data;
    end
  end

  // checks
  sequence s_end_taken;
    take && state == ST_END;
  endsequence
  sequence s_reply_entered;
    state == ST_REPLY && !rx_ready;
  endsequence

  property p_no_end;
    @(posedge clk) disable iff (!rst_n)
      s_end_taken ##0 (rx_data != END_BYTE && !drop)
      |=> s_reply_entered ##0 rsp.stat == STAT_PACKET_ERR;
  endproperty
  a_no_end: assert property (p_no_end) else $error("missing end byte not reported");

  property p_bad_sum;
    @(posedge clk) disable iff (!rst_n)
      s_end_taken ##0 (rx_data == END_BYTE && acc != 8'h00 && !drop)
      |=> rsp.stat == STAT_CHECKSUM_ERR;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("checksum error not reported");

  property p_hunt;
    @(posedge clk) disable iff (!rst_n)
      state == ST_IDLE && take && rx_data != CMD_START_BYTE |=> state == ST_IDLE;
  endproperty
  a_hunt: assert property (p_hunt) else $error("stray byte left start hunt");

  property p_enc_query;
    @(posedge clk) disable iff (!rst_n)
      s_end_taken ##0 (rx_data == END_BYTE && acc == 8'h00 && len == LEN_QUERY_CMD
      && pl[0] == CMD_QUERY && enc_seen) |=> rsp.stat == STAT_ACCEPT_ERR && !rsp.data_kind;
  endproperty
  a_enc_query: assert property (p_enc_query) else $error("query accepted after encrypted write");

  property p_first_byte;
    @(posedge clk) disable iff (!rst_n)
      push && idx == 4'h0 |-> push_data == REPLY_START_BYTE;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply not opened by start byte");

  property p_code_order;
    @(posedge clk) disable iff (!rst_n)
      push && rsp.data_kind && idx == IDX_CODE_HI |-> push_data == rsp.csize[15:8] ##1
      (!push || push_data == rsp.csize[7:0]);
  endproperty
  a_code_order: assert property (p_code_order) else $error("code size byte order wrong");

  property p_l2_refuse;
    @(posedge clk) disable iff (!rst_n)
      disable_level_two_key |=> init_refused && rma_refused;
  endproperty
  a_l2_refuse: assert property (p_l2_refuse) else $error("level-two disable not blocking");

  property p_no_store_on_err;
    @(posedge clk) disable iff (!rst_n)
      s_end_taken ##0 next_rsp.stat != STAT_OK |=> $stable(disable_level_one_key)
      && $stable(disable_init) && $stable(disable_level_two_key) && $stable(disable_locked_boot);
  endproperty
  a_no_store_on_err: assert property (p_no_store_on_err) else $error("store changed on error");

  property p_l1_after_enc;
    @(posedge clk) disable iff (!rst_n)
      s_end_taken ##0 (enc_seen && !disable_level_one_key) |=> !disable_level_one_key;
  endproperty
  a_l1_after_enc: assert property (p_l1_after_enc) else $error("level-one key disabled after write");
endmodule

`default_nettype wire

// ==== verilog/bbpc_pkg.sv ====
// constants, state encoding and reply carrier for the boot command interpreter
// assumes one clock domain; imported by the interpreter, the host model and the testbench
package bbpc_pkg;
  // framing bytes and codes
  localparam logic [7:0] CMD_START_BYTE = 8'h01;
  localparam logic [7:0] REPLY_START_BYTE = 8'h81;
  localparam logic [7:0] END_BYTE = 8'h03;
  localparam logic [7:0] LEN_HIGH_ZERO = 8'h00;
  localparam logic [7:0] CMD_QUERY = 8'h4F;
  localparam logic [7:0] CMD_PARAM = 8'h51;
  localparam logic [7:0] RSP_QUERY_ERR = 8'hCF;
  localparam logic [7:0] RSP_PARAM_ERR = 8'hD1;
  localparam logic [7:0] LEN_QUERY_REPLY = 8'h0B;
  localparam logic [7:0] LEN_STATUS_REPLY = 8'h0A;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] LEN_QUERY_CMD = 16'h0001;
  localparam logic [15:0] LEN_PARAM_CMD = 16'h0003;
  localparam logic [15:0] FMT_MAX_LEN = 16'h0400;
  localparam logic [31:0] UNUSED_CODE = 32'hFFFFFFFF;
  // status codes
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_PACKET_ERR = 8'hC1;
  localparam logic [7:0] STAT_CHECKSUM_ERR = 8'hC2;
  localparam logic [7:0] STAT_ACCEPT_ERR = 8'hC3;
  localparam logic [7:0] STAT_PARAM_ERR = 8'hC5;
  localparam logic [7:0] STAT_SECURE_ERR = 8'hDA;
  // parameter identifiers and value field
  localparam logic [7:0] PID_INIT = 8'h01;
  localparam logic [7:0] PID_LOCKED_BOOT = 8'h02;
  localparam logic [7:0] PID_L2_KEY = 8'h03;
  localparam logic [7:0] PID_L1_KEY = 8'h04;
  localparam logic [2:0] VAL_DISABLE = 3'h0;
  // authentication levels
  localparam logic [1:0] AUTH_LEVEL_ZERO = 2'h0;
  localparam logic [1:0] AUTH_LEVEL_ONE = 2'h1;
  localparam logic [1:0] AUTH_LEVEL_TWO = 2'h2;
  // reply byte positions
  localparam logic [3:0] IDX_LEN_HIGH = 4'h1;
  localparam logic [3:0] IDX_LEN_LOW = 4'h2;
  localparam logic [3:0] IDX_RESP = 4'h3;
  localparam logic [3:0] IDX_STAT = 4'h4;
  localparam logic [3:0] IDX_CODE_HI = 4'h6;
  localparam logic [3:0] IDX_CODE_LO = 4'h7;
  localparam logic [3:0] IDX_DATA_HI = 4'h8;
  localparam logic [3:0] IDX_DATA_LO = 4'h9;
  localparam logic [3:0] LAST_DATA = 4'hF;
  localparam logic [3:0] LAST_STATUS = 4'hE;
  // fifo shape
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_LEN_HIGH = 3'h1, ST_LEN_LOW = 3'h3, ST_BODY = 3'h2,
    ST_SUM = 3'h6, ST_END = 3'h7, ST_REPLY = 3'h5
  } bbpc_state_t;

  typedef struct packed {
    logic data_kind;
    logic [7:0] resp;
    logic [7:0] stat;
    logic [15:0] csize;
    logic [15:0] dsize;
  } bbpc_reply_t;
endpackage

// ==== verif/bbpc_host.sv ====
// host model: frames commands onto the receive stream, collects reply bytes
// assumes the interpreter's byte streams on clk; all drive at the falling edge
`timescale 1ns/10ps
`default_nettype none
module bbpc_host (
  input wire logic clk, // clock
  output logic [7:0] rx_data, // command byte
  output logic rx_valid, // command byte present
  input wire logic rx_ready, // command byte taken
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply byte present
  output logic tx_ready // reply byte taken
);
  import bbpc_pkg::*;
  logic [7:0] got[$];
  int slow = 0;
  int cyc = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // offer one byte, held until a rising edge finds rx_ready high
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx_data = b;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1) @(negedge clk);
  endtask
  // whole frame; sum makes length through payload total zero
  task automatic send(input logic [7:0] pl[$], input logic [7:0] len, input logic bad,
    input logic [7:0] endb);
    logic [7:0] s;
    s = 8'h00 - len;
    put(CMD_START_BYTE);
    put(LEN_HIGH_ZERO);
    put(len);
    foreach (pl[i]) begin
      put(pl[i]);
      s = s - pl[i];
    end
    put(bad ? ~s : s);
    put(endb);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released line shows no stale byte
  endtask
  // reply reader: 0 prompt, 1 slow, 2 stalled; bytes recorded before their edge
  always @(negedge clk) begin
    cyc = cyc + 1;
    tx_ready = (slow == 0) || (slow == 1 && cyc % 3 == 0);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: table of command frames, then stall, encrypted write, reset, fifo
// assumes bbpc_top and its package; the fifo is exercised through the top only
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bbpc_pkg::*;
  typedef struct packed {
    logic [23:0] pl;
    logic [1:0] n;
    logic [7:0] len;
    logic bad;
    logic [7:0] endb;
    logic [1:0] auth;
    logic [7:0] resp;
    logic [7:0] stat;
  } bbpc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [1:0] auth_level = 2'h2;
  logic enc = 1'b0;
  logic [15:0] csize = 16'h0100;
  logic [15:0] dsize = 16'h0004;
  logic d_init, d_lb, d_l2, d_l1, i_ref, r_ref;
  logic [7:0] exp[$];
  bbpc_row_t rows[12];
  int n_mismatch = 0;
  int checks_done = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  bbpc_top bbpc_top_inst (.clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .auth_level(auth_level), .enc_write_done(enc), .code_secure_size(csize),
    .data_secure_size(dsize), .disable_init(d_init), .disable_locked_boot(d_lb),
    .disable_level_two_key(d_l2), .disable_level_one_key(d_l1), .init_refused(i_ref),
    .rma_refused(r_ref));
  bbpc_host bbpc_host_inst (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  // compare helpers, one per result kind
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask
  // send n payload bytes, first byte in the top of pl
  task automatic run(input logic [23:0] pl, input logic [1:0] n, input logic [7:0] len,
    input logic bad, input logic [7:0] endb);
    logic [7:0] q[$];
    for (int i = 0; i < n; i++) q.push_back(pl[23-8*i -: 8]);
    bbpc_host_inst.send(q, len, bad, endb);
  endtask
  // expected reply: data packet for a good query, else status packet
  task automatic mk(input logic [7:0] resp, input logic [7:0] stat);
    logic [7:0] s;
    if (resp == CMD_QUERY) begin
      exp = '{REPLY_START_BYTE, ZERO_BYTE, LEN_QUERY_REPLY, resp, ZERO_BYTE, ZERO_BYTE,
        csize[15:8], csize[7:0], dsize[15:8], dsize[7:0]};
      repeat (4) exp.push_back(ZERO_BYTE);
    end else begin
      exp = '{REPLY_START_BYTE, ZERO_BYTE, LEN_STATUS_REPLY, resp, stat};
      repeat (8) exp.push_back(8'hFF);
    end
    s = 8'h00;
    for (int i = 1; i < exp.size(); i++) s = s - exp[i];
    exp.push_back(s);
    exp.push_back(END_BYTE);
  endtask
  // wait for the whole reply under a bound, then compare byte by byte
  task automatic chk_reply();
    int t;
    t = 0;
    while (bbpc_host_inst.got.size() < exp.size() && t < 400) begin
      @(negedge clk);
      t++;
    end
    foreach (exp[i]) begin
      chk8(i < bbpc_host_inst.got.size() ? bbpc_host_inst.got[i] : 8'hXX, exp[i], "reply");
    end
    bbpc_host_inst.got.delete();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: far beyond the several hundred cycles the tests need
  initial begin
    #1000000;
    n_mismatch++;
    close_out();
  end
  // main sequence
  initial begin
    bbpc_row_t r;
    rows[0] = '{24'h4F0000, 2'h1, 8'h01, 1'b0, 8'h03, 2'h2, 8'h4F, 8'h00};
    rows[1] = '{24'h4F0000, 2'h1, 8'h01, 1'b0, 8'h00, 2'h2, 8'hCF, 8'hC1};
    rows[2] = '{24'h4F0000, 2'h1, 8'h01, 1'b1, 8'h03, 2'h2, 8'hCF, 8'hC2};
    rows[3] = '{24'h4F0000, 2'h1, 8'h01, 1'b1, 8'h00, 2'h2, 8'hCF, 8'hC1};
    rows[4] = '{24'h4F0000, 2'h2, 8'h02, 1'b0, 8'h03, 2'h2, 8'hCF, 8'hC1};
    rows[5] = '{24'h510100, 2'h3, 8'h03, 1'b0, 8'h03, 2'h0, 8'h51, 8'h00};
    rows[6] = '{24'h510208, 2'h3, 8'h03, 1'b0, 8'h03, 2'h1, 8'h51, 8'h00};
    rows[7] = '{24'h510500, 2'h3, 8'h03, 1'b0, 8'h03, 2'h2, 8'hD1, 8'hC5};
    rows[8] = '{24'h510300, 2'h3, 8'h03, 1'b0, 8'h03, 2'h1, 8'hD1, 8'hDA};
    rows[9] = '{24'h510201, 2'h3, 8'h03, 1'b0, 8'h03, 2'h2, 8'hD1, 8'hC5};
    rows[10] = '{24'h510100, 2'h2, 8'h02, 1'b0, 8'h03, 2'h2, 8'hD1, 8'hC1};
    rows[11] = '{24'h510400, 2'h3, 8'h03, 1'b0, 8'h03, 2'h0, 8'hD1, 8'hDA};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      auth_level = r.auth;
      bbpc_host_inst.put(8'h7E);
      run(r.pl, r.n, r.len, r.bad, r.endb);
      mk(r.resp, r.stat);
      chk_reply();
      $display("row %0d done", i);
    end
    // only the two good stores may have changed the flags
    chk1(d_init, 1'b1, "init off");
    chk1(d_lb, 1'b1, "locked boot off");
    chk1(d_l2, 1'b0, "l2 key");
    chk1(d_l1, 1'b0, "l1 key");
    chk1(i_ref, 1'b1, "init refused");
    chk1(r_ref, 1'b0, "return refused");
    // stalled reader: the first reply byte waits in place
    auth_level = 2'h2;
    bbpc_host_inst.slow = 2;
    run(24'h4F0000, 2'h1, 8'h01, 1'b0, END_BYTE);
    repeat (40) @(negedge clk);
    chk1(tx_valid, 1'b1, "stall valid");
    chk8(tx_data, REPLY_START_BYTE, "stall data");
    bbpc_host_inst.slow = 1;
    mk(CMD_QUERY, STAT_OK);
    chk_reply();
    bbpc_host_inst.slow = 0;
    $display("stall done");
    // encrypted write executed: query and level-one key refused
    enc = 1'b1;
    @(negedge clk);
    enc = 1'b0;
    run(24'h4F0000, 2'h1, 8'h01, 1'b0, END_BYTE);
    mk(RSP_QUERY_ERR, STAT_ACCEPT_ERR);
    chk_reply();
    run(24'h4F0000, 2'h1, 8'h01, 1'b1, END_BYTE);
    mk(RSP_QUERY_ERR, STAT_CHECKSUM_ERR);
    chk_reply();
    run(24'h510400, 2'h3, 8'h03, 1'b0, END_BYTE);
    mk(RSP_PARAM_ERR, STAT_ACCEPT_ERR);
    chk_reply();
    run(24'h510300, 2'h3, 8'h03, 1'b0, END_BYTE);
    mk(CMD_PARAM, STAT_OK);
    chk_reply();
    repeat (2) @(negedge clk);
    chk1(d_l2, 1'b1, "l2 key off");
    chk1(d_l1, 1'b0, "l1 key kept");
    chk1(r_ref, 1'b1, "return refused");
    $display("encrypted write done");
    // reset clears the flags and the encrypted write history
    rst_n = 1'b0;
    @(negedge clk);
    chk1(rx_ready, 1'b1, "reset ready");
    chk1(tx_valid, 1'b0, "reset valid");
    chk1(d_l2, 1'b0, "reset l2");
    chk1(r_ref, 1'b0, "reset return");
    rst_n = 1'b1;
    csize = 16'h8001;
    dsize = 16'h7FFE;
    run(24'h4F0000, 2'h1, 8'h01, 1'b0, END_BYTE);
    mk(CMD_QUERY, STAT_OK);
    chk_reply();
    // write history gone: the level-one key may now be disabled
    run(24'h510400, 2'h3, 8'h03, 1'b0, END_BYTE);
    mk(CMD_PARAM, STAT_OK);
    chk_reply();
    chk1(d_l1, 1'b1, "l1 key off");
    $display("reset done");
    // fifo through the top: a stalled reader fills it and keeps receive closed
    bbpc_host_inst.slow = 2;
    run(24'h510500, 2'h3, 8'h03, 1'b0, END_BYTE);
    repeat (20) @(negedge clk);
    chk1(rx_ready, 1'b0, "fifo full");
    chk1(tx_valid, 1'b1, "fifo valid");
    chk8(tx_data, REPLY_START_BYTE, "fifo head");
    bbpc_host_inst.slow = 0;
    mk(RSP_PARAM_ERR, STAT_PARAM_ERR);
    chk_reply();
    @(negedge clk);
    chk1(tx_valid, 1'b0, "fifo empty");
    $display("fifo done");
    close_out();
  end
endmodule
`default_nettype wire
